/* include/sdr_pkg.sv */
// Constants and types for the signed divide and range extreme unit.
// Assumes a single 125 MHz clock and an instruction sequencer on plain ports.
//
// Notes on behaviour
// - Word divide: 16-bit signed by 16-bit signed.
// - Word divide: quotient first, remainder next word.
// - Zero divisor raises fault, no valid result.
// - Word divide: zero flag when quotient zero.
// - Long divide: 32-bit signed by 32-bit signed.
// - Long divide: quotient words 0-1, remainder 2-3.
// - Long divide: zero flag when 32-bit quotient zero.
// - Peak search writes largest of N words.
// - Floor search writes smallest of N words.
// - N is three low BCD digits, 001..999.
// - Control bit 14 also reports winner location.
// - Winner in data memory: absolute word address.
// - Winner elsewhere: offset from first range word.
// - Ties report the lowest-addressed word.
// - Control bit 15 selects signed comparison.
// - Signed mode treats 8000 and above negative.
// - Fault on bad BCD length or area crossing.
// - Peak search: zero flag when maximum zero.
// - Floor search: zero flag when minimum zero.
// - Condition false: only done pulses, other outputs unchanged.
// - Missing indirect data memory operand raises fault.
// - Signed values are two's complement.
`default_nettype none
package sdr_pkg;
   localparam int SDR_DIV_W = 32;
   localparam int SDR_DIV_STEPS = 32;
   localparam int SDR_BIT_LOC = 14;
   localparam int SDR_BIT_SIGNED = 15;
   localparam logic [15:0] SDR_SIGN_BIT = 16'h8000;
   localparam logic [9:0] SDR_N_MAX = 10'h3E7;
   localparam logic [9:0] SDR_N_MIN = 10'h001;
   localparam logic [15:0] SDR_WORD_RST = 16'h0000;

   typedef enum logic [1:0] {
      SDR_OP_WDIV,
      SDR_OP_LDIV,
      SDR_OP_PEAK,
      SDR_OP_FLOOR
   } sdr_op_t;

   typedef enum logic [2:0] {
      SDR_AREA_IO,
      SDR_AREA_DATA,
      SDR_AREA_LINK,
      SDR_AREA_OTHER
   } sdr_area_t;
endpackage : sdr_pkg
`default_nettype wire

/* include/sdr_div_if.sv */
// Handshake between the top unit and its divider core.
// Assumes both ends share the unit clock.
`default_nettype none
interface sdr_div_if;
   logic start;
   logic is_signed;
   logic [31:0] dividend;
   logic [31:0] divisor;
   logic done;
   logic [31:0] quotient;
   logic [31:0] remainder;
   modport ctrl (output start, is_signed, dividend, divisor, input done, quotient, remainder);
   modport core (input start, is_signed, dividend, divisor, output done, quotient, remainder);
endinterface : sdr_div_if
`default_nettype wire

/* hdl/sdr_div_core.sv */
// Iterative restoring divider, one quotient bit per cycle.
// Assumes a nonzero divisor; the top screens zero before starting.
`default_nettype none
module sdr_div_core
   import sdr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Divide request
   sdr_div_if.core div
);
   import sdr_pkg::*;

   logic [31:0] num_q, num_d, den_q, den_d, rem_q, rem_d;
   logic [5:0] cnt_q, cnt_d;
   logic busy_q, busy_d, neg_q_q, neg_q_d, neg_r_q, neg_r_d, done_q, done_d;
   logic [32:0] trial;
   logic [31:0] shifted;

   function automatic logic [31:0] sdr_abs(input logic [31:0] v, input logic sgn);
      sdr_abs = (sgn && v[31]) ? 32'(-v) : v;
   endfunction

   always_comb begin
      num_d = num_q;
      den_d = den_q;
      rem_d = rem_q;
      cnt_d = cnt_q;
      busy_d = busy_q;
      neg_q_d = neg_q_q;
      neg_r_d = neg_r_q;
      done_d = 1'b0;
      shifted = {rem_q[30:0], num_q[31]};
      trial = {1'b0, shifted} - {1'b0, den_q};
      if (!busy_q && div.start) begin
         // Divide magnitudes, fix signs after: truncation toward zero
         num_d = sdr_abs(div.dividend, div.is_signed);
         den_d = sdr_abs(div.divisor, div.is_signed);
         neg_q_d = div.is_signed && (div.dividend[31] ^ div.divisor[31]);
         neg_r_d = div.is_signed && div.dividend[31];
         rem_d = '0;
         cnt_d = 6'(SDR_DIV_STEPS);
         busy_d = 1'b1;
      end else if (busy_q) begin
         num_d = {num_q[30:0], ~trial[32]};
         rem_d = trial[32] ? shifted : trial[31:0];
         cnt_d = cnt_q - 6'h01;
         if (cnt_q == 6'h01) begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         num_q <= '0;
         den_q <= '0;
         rem_q <= '0;
         cnt_q <= '0;
         busy_q <= 1'b0;
         neg_q_q <= 1'b0;
         neg_r_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         num_q <= num_d;
         den_q <= den_d;
         rem_q <= rem_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         neg_q_q <= neg_q_d;
         neg_r_q <= neg_r_d;
         done_q <= done_d;
      end
   end

   assign div.done = done_q;
   assign div.quotient = neg_q_q ? 32'(-num_q) : num_q;
   assign div.remainder = neg_r_q ? 32'(-rem_q) : rem_q;
endmodule : sdr_div_core
`default_nettype wire

/* hdl/sdr_unit.sv */
// Divide and range extreme execution unit for the instruction sequencer.
// Assumes operands stay stable from start until done; range words are
// fetched over a one-word read port with one cycle of latency.
`default_nettype none
module sdr_unit
   import sdr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Command
   input wire logic start,
   input wire logic exec_cond,
   input wire sdr_pkg::sdr_op_t op,
   input wire logic operand_fault,
   // Divide operands
   input wire logic [15:0] dividend_word_lo,
   input wire logic [15:0] dividend_word_hi,
   input wire logic [15:0] divisor_word_lo,
   input wire logic [15:0] divisor_word_hi,
   // Range search operands
   input wire logic [15:0] control_word,
   input wire logic [15:0] range_base,
   input wire sdr_pkg::sdr_area_t first_area,
   input wire sdr_pkg::sdr_area_t last_area,
   // Range word read port
   output logic rd_req,
   output logic [15:0] rd_addr,
   input wire logic [15:0] rd_data,
   // Results
   output logic done,
   output logic result_we,
   output logic [3:0] result_valid,
   output logic [15:0] result_w0,
   output logic [15:0] result_w1,
   output logic [15:0] result_w2,
   output logic [15:0] result_w3,
   output logic fault_flag,
   output logic zero_result_flag
);
   import sdr_pkg::*;

   typedef enum logic [2:0] {
      SDR_IDLE,
      SDR_DIVIDE,
      SDR_SCAN,
      SDR_LAST,
      SDR_FINISH
   } sdr_state_t;

   sdr_state_t state_q, state_d;
   sdr_op_t op_q, op_d;
   logic [9:0] n_q, n_d, idx_q, idx_d;
   logic [15:0] best_q, best_d, loc_q, loc_d;
   logic have_q, have_d, sgn_q, sgn_d, locen_q, locen_d, abs_loc_q, abs_loc_d;
   logic rd_req_q, rd_req_d;
   logic [15:0] rd_addr_q, rd_addr_d;
   logic [9:0] rd_idx_q, rd_idx_d;
   // Delayed copy of the request, lines up with rd_data
   logic got_q, got_d;
   logic [15:0] got_addr_q, got_addr_d;
   logic [9:0] got_idx_q, got_idx_d;
   logic done_q, done_d, we_q, we_d, fault_q, fault_d, zero_q, zero_d;
   logic [3:0] valid_q, valid_d;
   logic [15:0] w0_q, w0_d, w1_q, w1_d, w2_q, w2_d, w3_q, w3_d;
   logic [9:0] n_bin;
   logic bcd_ok, better;
   logic div_start_q, div_start_d;

   sdr_div_if div_bus ();

   sdr_div_core u_div (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .div(div_bus.core)
   );

   function automatic logic sdr_digit_ok(input logic [3:0] d);
      sdr_digit_ok = (d <= 4'h9);
   endfunction

   // Ranking: bit 15 of control picks signed order
   function automatic logic sdr_beats(input logic [15:0] a, input logic [15:0] b, input logic sgn,
                                      input logic want_max);
      logic [15:0] ka, kb;
      ka = sgn ? (a ^ SDR_SIGN_BIT) : a;
      kb = sgn ? (b ^ SDR_SIGN_BIT) : b;
      // Strict compare keeps the first winner on ties
      sdr_beats = want_max ? (ka > kb) : (ka < kb);
   endfunction

   always_comb begin
      bcd_ok = sdr_digit_ok(control_word[11:8]) && sdr_digit_ok(control_word[7:4]) &&
               sdr_digit_ok(control_word[3:0]);
      n_bin = 10'(control_word[11:8]) * 10'h064 + 10'(control_word[7:4]) * 10'h00A +
              10'(control_word[3:0]);
   end

   assign div_bus.start = div_start_q;
   assign div_bus.is_signed = 1'b1;
   assign div_bus.dividend = (op_q == SDR_OP_LDIV) ? {dividend_word_hi, dividend_word_lo}
                                                   : {{16{dividend_word_lo[15]}}, dividend_word_lo};
   assign div_bus.divisor = (op_q == SDR_OP_LDIV) ? {divisor_word_hi, divisor_word_lo}
                                                  : {{16{divisor_word_lo[15]}}, divisor_word_lo};

   always_comb begin
      state_d = state_q;
      op_d = op_q;
      n_d = n_q;
      idx_d = idx_q;
      best_d = best_q;
      loc_d = loc_q;
      have_d = have_q;
      sgn_d = sgn_q;
      locen_d = locen_q;
      abs_loc_d = abs_loc_q;
      rd_req_d = 1'b0;
      rd_addr_d = rd_addr_q;
      rd_idx_d = rd_idx_q;
      // Read data trails its request by one cycle
      got_d = rd_req_q;
      got_addr_d = rd_addr_q;
      got_idx_d = rd_idx_q;
      done_d = 1'b0;
      we_d = 1'b0;
      valid_d = valid_q;
      fault_d = fault_q;
      zero_d = zero_q;
      w0_d = w0_q;
      w1_d = w1_q;
      w2_d = w2_q;
      w3_d = w3_q;
      div_start_d = 1'b0;
      better = 1'b0;
      case (state_q)
         SDR_IDLE: begin
            // Condition false: answer at once, touch nothing
            if (start && !exec_cond) begin
               done_d = 1'b1;
            end else if (start) begin
               op_d = op;
               if (operand_fault) begin
                  fault_d = 1'b1;
                  done_d = 1'b1;
               end else if (op == SDR_OP_WDIV || op == SDR_OP_LDIV) begin
                  if (divisor_word_lo == 16'h0000 &&
                      (op == SDR_OP_WDIV || divisor_word_hi == 16'h0000)) begin
                     fault_d = 1'b1;
                     done_d = 1'b1;
                  end else begin
                     div_start_d = 1'b1;
                     state_d = SDR_DIVIDE;
                  end
               end else if (!bcd_ok || n_bin < SDR_N_MIN || n_bin > SDR_N_MAX || first_area != last_area) begin
                  fault_d = 1'b1;
                  done_d = 1'b1;
               end else begin
                  n_d = n_bin;
                  idx_d = '0;
                  have_d = 1'b0;
                  sgn_d = control_word[SDR_BIT_SIGNED];
                  locen_d = control_word[SDR_BIT_LOC];
                  abs_loc_d = (first_area == SDR_AREA_DATA);
                  rd_req_d = 1'b1;
                  rd_addr_d = range_base;
                  rd_idx_d = '0;
                  state_d = SDR_SCAN;
               end
            end
         end
         SDR_DIVIDE: begin
            if (div_bus.done) begin
               fault_d = 1'b0;
               we_d = 1'b1;
               done_d = 1'b1;
               state_d = SDR_IDLE;
               w0_d = div_bus.quotient[15:0];
               if (op_q == SDR_OP_WDIV) begin
                  w1_d = div_bus.remainder[15:0];
                  valid_d = 4'h3;
                  zero_d = (div_bus.quotient[15:0] == 16'h0000);
               end else begin
                  w1_d = div_bus.quotient[31:16];
                  w2_d = div_bus.remainder[15:0];
                  w3_d = div_bus.remainder[31:16];
                  valid_d = 4'hF;
                  zero_d = (div_bus.quotient == 32'h0000_0000);
               end
            end
         end
         SDR_SCAN, SDR_LAST: begin
            // Word requested last cycle is on rd_data now
            if (got_q) begin
               better = !have_q || sdr_beats(rd_data, best_q, sgn_q, op_q == SDR_OP_PEAK);
               if (better) begin
                  best_d = rd_data;
                  // Data memory reports address, others offset
                  loc_d = abs_loc_q ? got_addr_q : 16'(got_idx_q);
                  have_d = 1'b1;
               end
            end
            if (state_q == SDR_LAST) begin
               state_d = SDR_FINISH;
            end else if (idx_q + 10'h001 < n_q) begin
               idx_d = idx_q + 10'h001;
               rd_req_d = 1'b1;
               rd_addr_d = range_base + 16'(idx_q + 10'h001);
               rd_idx_d = idx_q + 10'h001;
            end else begin
               // One more cycle so the last word can arrive
               state_d = SDR_LAST;
            end
         end
         SDR_FINISH: begin
            fault_d = 1'b0;
            we_d = 1'b1;
            done_d = 1'b1;
            w0_d = best_q;
            zero_d = (best_q == 16'h0000);
            if (locen_q) begin
               w1_d = loc_q;
               valid_d = 4'h3;
            end else begin
               valid_d = 4'h1;
            end
            state_d = SDR_IDLE;
         end
         default: state_d = SDR_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= SDR_IDLE;
         op_q <= SDR_OP_WDIV;
         n_q <= '0;
         idx_q <= '0;
         best_q <= SDR_WORD_RST;
         loc_q <= SDR_WORD_RST;
         have_q <= 1'b0;
         sgn_q <= 1'b0;
         locen_q <= 1'b0;
         abs_loc_q <= 1'b0;
         rd_req_q <= 1'b0;
         rd_addr_q <= SDR_WORD_RST;
         rd_idx_q <= '0;
         got_q <= 1'b0;
         got_addr_q <= SDR_WORD_RST;
         got_idx_q <= '0;
         done_q <= 1'b0;
         we_q <= 1'b0;
         valid_q <= 4'h0;
         fault_q <= 1'b0;
         zero_q <= 1'b0;
         w0_q <= SDR_WORD_RST;
         w1_q <= SDR_WORD_RST;
         w2_q <= SDR_WORD_RST;
         w3_q <= SDR_WORD_RST;
         div_start_q <= 1'b0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         n_q <= n_d;
         idx_q <= idx_d;
         best_q <= best_d;
         loc_q <= loc_d;
         have_q <= have_d;
         sgn_q <= sgn_d;
         locen_q <= locen_d;
         abs_loc_q <= abs_loc_d;
         rd_req_q <= rd_req_d;
         rd_addr_q <= rd_addr_d;
         rd_idx_q <= rd_idx_d;
         got_q <= got_d;
         got_addr_q <= got_addr_d;
         got_idx_q <= got_idx_d;
         done_q <= done_d;
         we_q <= we_d;
         valid_q <= valid_d;
         fault_q <= fault_d;
         zero_q <= zero_d;
         w0_q <= w0_d;
         w1_q <= w1_d;
         w2_q <= w2_d;
         w3_q <= w3_d;
         div_start_q <= div_start_d;
      end
   end

   assign rd_req = rd_req_q;
   assign rd_addr = rd_addr_q;
   assign done = done_q;
   assign result_we = we_q;
   assign result_valid = valid_q;
   assign result_w0 = w0_q;
   assign result_w1 = w1_q;
   assign result_w2 = w2_q;
   assign result_w3 = w3_q;
   assign fault_flag = fault_q;
   assign zero_result_flag = zero_q;
endmodule : sdr_unit
`default_nettype wire

/* testbench/sdr_unit_monitor.sv */
// Assertion checker for the divide and range extreme unit.
// Assumes operands stay stable from an accepted start until done.
`default_nettype none
module sdr_unit_monitor
   import sdr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Command and operands
   input wire logic start,
   input wire logic exec_cond,
   input wire sdr_pkg::sdr_op_t op,
   input wire logic operand_fault,
   input wire logic [15:0] divisor_word_lo,
   input wire logic [15:0] divisor_word_hi,
   input wire logic [15:0] control_word,
   input wire logic [15:0] range_base,
   input wire sdr_pkg::sdr_area_t first_area,
   input wire sdr_pkg::sdr_area_t last_area,
   // Read port and results
   input wire logic rd_req,
   input wire logic [15:0] rd_addr,
   input wire logic done,
   input wire logic result_we,
   input wire logic [3:0] result_valid,
   input wire logic [15:0] result_w0,
   input wire logic [15:0] result_w1,
   input wire logic fault_flag,
   input wire logic zero_result_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   import sdr_pkg::*;

   logic busy_q, busy_d, take, srch, n_ok;
   // Starts while busy are ignored, so only idle starts count
   always_comb busy_d = done ? 1'b0 : (start | busy_q);
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) busy_q <= 1'b0;
      else busy_q <= busy_d;
   end
   assign take = start && !busy_q && exec_cond && !operand_fault;
   assign srch = op == SDR_OP_PEAK || op == SDR_OP_FLOOR;
   assign n_ok = control_word[11:8] < 4'hA && control_word[7:4] < 4'hA && control_word[3:0] < 4'hA
      && control_word[11:0] != 12'h000 && first_area == last_area;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   property p_done; done |=> !done; endproperty
   a_done: assert property (p_done) else $error("done longer than one cycle");
   property p_we; result_we |-> done; endproperty
   a_we: assert property (p_we) else $error("result write without done");
   property p_skip; start && !busy_q && !exec_cond |=> done && !result_we && $stable(result_w0)
      && $stable(fault_flag) && $stable(zero_result_flag); endproperty
   a_skip: assert property (p_skip) else $error("skipped command changed outputs");
   property p_opf; start && !busy_q && exec_cond && operand_fault |=> done && fault_flag && !result_we; endproperty
   a_opf: assert property (p_opf) else $error("missing operand not faulted");
   property p_div0; take && ((op == SDR_OP_WDIV && divisor_word_lo == 16'h0000) || (op == SDR_OP_LDIV
      && {divisor_word_hi, divisor_word_lo} == 32'h0)) |=> done && fault_flag && $stable(result_w0); endproperty
   a_div0: assert property (p_div0) else $error("zero divisor not faulted");
   property p_ldiv; take && op == SDR_OP_LDIV && {divisor_word_hi, divisor_word_lo} != 32'h0
      |-> ##35 done && result_we && result_valid == 4'hF; endproperty
   a_ldiv: assert property (p_ldiv) else $error("long divide result late or partial");
   property p_wz; done && result_we && op == SDR_OP_WDIV
      |-> zero_result_flag == (result_w0 == 16'h0000) && result_valid == 4'h3; endproperty
   a_wz: assert property (p_wz) else $error("word divide zero flag wrong");
   property p_lz; done && result_we && op == SDR_OP_LDIV
      |-> zero_result_flag == ({result_w1, result_w0} == 32'h0); endproperty
   a_lz: assert property (p_lz) else $error("long divide zero flag wrong");
   property p_sz; done && result_we && srch |-> zero_result_flag == (result_w0 == 16'h0000); endproperty
   a_sz: assert property (p_sz) else $error("search zero flag wrong");
   property p_bad; take && srch && !n_ok |=> done && fault_flag && !result_we; endproperty
   a_bad: assert property (p_bad) else $error("bad length or area not faulted");
   property p_rd; take && srch && n_ok |=> rd_req && rd_addr == range_base; endproperty
   a_rd: assert property (p_rd) else $error("search did not read first word");
endmodule // sdr_unit_monitor
bind sdr_unit sdr_unit_monitor mon_i (.ref_clk(ref_clk), .rstn(rstn), .start(start), .exec_cond(exec_cond),
   .op(op), .operand_fault(operand_fault), .divisor_word_lo(divisor_word_lo), .divisor_word_hi(divisor_word_hi),
   .control_word(control_word), .range_base(range_base), .first_area(first_area), .last_area(last_area),
   .rd_req(rd_req), .rd_addr(rd_addr), .done(done), .result_we(result_we), .result_valid(result_valid),
   .result_w0(result_w0), .result_w1(result_w1), .fault_flag(fault_flag), .zero_result_flag(zero_result_flag));
`default_nettype wire

/* testbench/sdr_mem_model.sv */
// Range word memory behind the unit's one-word read port.
// Assumes rd_req is a one-cycle request; data follows one cycle later.
`default_nettype none
module sdr_mem_model (
   // Clock
   input wire logic ref_clk,
   // Read port
   input wire logic rd_req,
   input wire logic [15:0] rd_addr,
   output var logic [15:0] rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [16];
   // Stale data flips each cycle so a late sample cannot match by luck
   always @(posedge ref_clk) begin
      if (rd_req) rd_data <= mem[rd_addr[3:0]];
      else rd_data <= ~rd_data;
   end
endmodule // sdr_mem_model
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the divide and range extreme unit.
// Assumes the memory model answers reads one cycle after the request.
`default_nettype none
module tb_top
   import sdr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rstn = 1'b0, start = 1'b0, exec_cond = 1'b0, operand_fault = 1'b0;
   sdr_op_t op = SDR_OP_WDIV;
   sdr_area_t first_area = SDR_AREA_DATA, last_area = SDR_AREA_DATA;
   logic [15:0] num_lo = 16'h0000, num_hi = 16'h0000, den_lo = 16'h0000, den_hi = 16'h0000;
   logic [15:0] ctrl = 16'h0000, base = 16'h0000;
   logic rd_req, done, result_we, fault_flag, zero_result_flag;
   logic [15:0] rd_addr, rd_data, w0, w1, w2, w3;
   logic [3:0] result_valid;
   int n_mismatch = 0, tests_run = 0, lat;
   always #4 ref_clk = ~ref_clk;
   sdr_unit dut (.ref_clk(ref_clk), .rstn(rstn), .start(start), .exec_cond(exec_cond), .op(op),
      .operand_fault(operand_fault), .dividend_word_lo(num_lo), .dividend_word_hi(num_hi),
      .divisor_word_lo(den_lo), .divisor_word_hi(den_hi), .control_word(ctrl), .range_base(base),
      .first_area(first_area), .last_area(last_area), .rd_req(rd_req), .rd_addr(rd_addr),
      .rd_data(rd_data), .done(done), .result_we(result_we), .result_valid(result_valid),
      .result_w0(w0), .result_w1(w1), .result_w2(w2), .result_w3(w3), .fault_flag(fault_flag),
      .zero_result_flag(zero_result_flag));
   sdr_mem_model mem_i (.ref_clk(ref_clk), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Called at a rising edge; returns at the falling edge where done shows
   task automatic go(input sdr_op_t o, input logic ec, input logic of, input int exp_lat);
      op <= o;
      exec_cond <= ec;
      operand_fault <= of;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      lat = 0;
      do begin
         @(negedge ref_clk);
         lat++;
      end while (done !== 1'b1 && lat < 1100);
      chk("latency", lat, exp_lat);
   endtask
   task automatic wdiv(input logic [15:0] a, b, q, r, input logic z);
      @(posedge ref_clk);
      num_lo <= a;
      den_lo <= b;
      go(SDR_OP_WDIV, 1'b1, 1'b0, 35);
      chk("wquot", w0, q);
      chk("wrem", w1, r);
      chk("wzero", zero_result_flag, z);
      chk("wvalid", result_valid, 4'h3);
   endtask
   task automatic ldiv(input logic [31:0] a, b, q, r);
      @(posedge ref_clk);
      {num_hi, num_lo} <= a;
      {den_hi, den_lo} <= b;
      go(SDR_OP_LDIV, 1'b1, 1'b0, 35);
      chk("lquot", {w1, w0}, q);
      chk("lrem", {w3, w2}, r);
      chk("lzero", zero_result_flag, q == 32'h0);
   endtask
   task automatic srch(input sdr_op_t o, input logic [15:0] c, b, input sdr_area_t ar,
      input logic [15:0] v, loc, input int n);
      @(posedge ref_clk);
      ctrl <= c;
      base <= b;
      first_area <= ar;
      last_area <= ar;
      go(o, 1'b1, 1'b0, n + 3);
      chk("extreme", w0, v);
      if (c[14]) chk("location", w1, loc);
      chk("szero", zero_result_flag, v == 16'h0);
      chk("svalid", result_valid, {2'b00, c[14], 1'b1});
   endtask
   task automatic flt(input sdr_op_t o, input logic of, input logic [15:0] keep);
      go(o, 1'b1, of, 1);
      chk("fault", fault_flag, 1'b1);
      chk("fault_we", result_we, 1'b0);
      chk("fault_w0", w0, keep);
   endtask
   task automatic t_divide();
      wdiv(16'hFFF9, 16'h0002, 16'hFFFD, 16'hFFFF, 1'b0);
      wdiv(16'h0064, 16'hFFF9, 16'hFFF2, 16'h0002, 1'b0);
      wdiv(16'h0001, 16'hFFFB, 16'h0000, 16'h0001, 1'b1);
      wdiv(16'h8000, 16'hFFFF, 16'h8000, 16'h0000, 1'b0);
      ldiv(32'hFFFF_FFF9, 32'h0000_0002, 32'hFFFF_FFFD, 32'hFFFF_FFFF);
      ldiv(32'h0003_0000, 32'h0001_0000, 32'h0000_0003, 32'h0000_0000);
      ldiv(32'h0000_0005, 32'hFFFF_FFFA, 32'h0000_0000, 32'h0000_0005);
   endtask
   task automatic t_search();
      mem_i.mem = '{0: 16'h0005, 1: 16'h8001, 2: 16'h0005, 3: 16'h0003, 4: 16'h0000, 9: 16'hFFFF,
         10: 16'h0002, 11: 16'h0002, 12: 16'h0002, 13: 16'h0002, 14: 16'h0002, 15: 16'h0002,
         default: 16'h0001};
      srch(SDR_OP_PEAK, 16'h4004, 16'h0100, SDR_AREA_DATA, 16'h8001, 16'h0101, 4);
      srch(SDR_OP_PEAK, 16'hC004, 16'h0100, SDR_AREA_IO, 16'h0005, 16'h0000, 4);
      srch(SDR_OP_FLOOR, 16'hC004, 16'h0100, SDR_AREA_DATA, 16'h8001, 16'h0101, 4);
      srch(SDR_OP_FLOOR, 16'h4004, 16'h0100, SDR_AREA_LINK, 16'h0003, 16'h0003, 4);
      srch(SDR_OP_FLOOR, 16'h4005, 16'h0100, SDR_AREA_LINK, 16'h0000, 16'h0004, 5);
      srch(SDR_OP_FLOOR, 16'h4004, 16'h0105, SDR_AREA_IO, 16'h0001, 16'h0000, 4);
      srch(SDR_OP_PEAK, 16'h0001, 16'h0102, SDR_AREA_OTHER, 16'h0005, 16'h0000, 1);
      srch(SDR_OP_PEAK, 16'h4010, 16'h0100, SDR_AREA_DATA, 16'hFFFF, 16'h0109, 10);
      srch(SDR_OP_PEAK, 16'h4999, 16'h0100, SDR_AREA_DATA, 16'hFFFF, 16'h0109, 999);
   endtask
   task automatic t_faults();
      @(posedge ref_clk);
      ctrl <= 16'h40A1;
      flt(SDR_OP_PEAK, 1'b0, 16'hFFFF);
      @(posedge ref_clk);
      ctrl <= 16'h4000;
      flt(SDR_OP_FLOOR, 1'b0, 16'hFFFF);
      @(posedge ref_clk);
      ctrl <= 16'h4004;
      last_area <= SDR_AREA_IO;
      flt(SDR_OP_PEAK, 1'b0, 16'hFFFF);
      @(posedge ref_clk);
      last_area <= SDR_AREA_DATA;
      flt(SDR_OP_FLOOR, 1'b1, 16'hFFFF);
      @(posedge ref_clk);
      den_lo <= 16'h0000;
      den_hi <= 16'h0001;
      flt(SDR_OP_WDIV, 1'b0, 16'hFFFF);
      @(posedge ref_clk);
      den_hi <= 16'h0000;
      flt(SDR_OP_LDIV, 1'b0, 16'hFFFF);
      chk("zero_kept", zero_result_flag, 1'b0);
   endtask
   task automatic t_skip();
      wdiv(16'h0009, 16'h0003, 16'h0003, 16'h0000, 1'b0);
      chk("fault_clear", fault_flag, 1'b0);
      @(posedge ref_clk);
      num_lo <= 16'h0000;
      den_lo <= 16'h0000;
      go(SDR_OP_WDIV, 1'b0, 1'b0, 1);
      chk("skip_we", result_we, 1'b0);
      chk("skip_fault", fault_flag, 1'b0);
      chk("skip_w0", w0, 16'h0003);
   endtask
   // Reset while idle after the fault tests: result outputs drop to zero
   task automatic t_reset();
      @(posedge ref_clk);
      rstn <= 1'b0;
      @(posedge ref_clk);
      chk("rst_w0", w0, 16'h0000);
      chk("rst_valid", result_valid, 4'h0);
      chk("rst_fault", fault_flag, 1'b0);
      chk("rst_done", done, 1'b0);
      rstn <= 1'b1;
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      t_divide();
      t_search();
      t_faults();
      t_reset();
      t_skip();
      stop_test();
   end
   // Whole run is under 2000 cycles; ten times that means a hang
   initial begin
      #(8 * 20000);
      n_mismatch++;
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
